// ==== rtl/gp_pkg.sv ====
// Purpose: Shared constants and types for the genset operator panel.
// Assumes: 100 MHz system clock, one-second housekeeping tick.
// Notes: Register offsets are byte addresses on the AHB-Lite slave.
package gp_pkg;
  // Clock and timer figures
  localparam int GP_CLK_PERIOD_NS = 10;
  localparam int GP_TICK_PERIOD_MS = 1000;
  localparam int GP_TICK_CYCLES = GP_TICK_PERIOD_MS * 1000000 / GP_CLK_PERIOD_NS;
  localparam logic [4:0] GP_BROWSE_TIMEOUT_S = 5'h1E;
  localparam logic [2:0] GP_ALT_PERIOD_S = 3'h5;
  // Fault history depth and code width
  localparam logic [3:0] GP_HIST_DEPTH = 4'hA;
  localparam int GP_CODE_W = 16;
  // Voltage trim, in volts
  localparam logic [9:0] GP_NOM_480 = 10'h1E0;
  localparam logic [9:0] GP_NOM_240 = 10'h0F0;
  localparam int GP_TRIM_UP_PCT = 5;
  localparam int GP_TRIM_DN_PCT = 15;
  localparam logic [9:0] GP_MAX_480 = 10'(GP_NOM_480 * (100 + GP_TRIM_UP_PCT) / 100);
  localparam logic [9:0] GP_MIN_480 = 10'(GP_NOM_480 * (100 - GP_TRIM_DN_PCT) / 100);
  localparam logic [9:0] GP_MAX_240 = 10'(GP_NOM_240 * (100 + GP_TRIM_UP_PCT) / 100);
  localparam logic [9:0] GP_MIN_240 = 10'(GP_NOM_240 * (100 - GP_TRIM_DN_PCT) / 100);
  localparam logic [9:0] GP_TRIM_STEP_V = 10'h001;
  // Register map
  localparam logic [7:0] GP_CTRL_OFS = 8'h00;
  localparam logic [7:0] GP_STAT_OFS = 8'h04;
  localparam logic [7:0] GP_TRIM_OFS = 8'h08;
  localparam logic [7:0] GP_HIST_OFS = 8'h0C;
  localparam logic [31:0] GP_CTRL_RST = 32'h0000_0000;
  localparam int GP_CTRL_NOM240_BIT = 0;
  localparam int GP_CTRL_PRE_LSB = 8;
  localparam int GP_CTRL_START_LSB = 16;
  localparam int GP_CTRL_STOP_LSB = 24;
  // Operating modes and display messages
  typedef enum logic [1:0] {GP_OFF, GP_MANUAL, GP_AUTO} gp_mode_t;
  typedef enum logic [3:0] {
    GP_MSG_ESTAB, GP_MSG_REESTAB, GP_MSG_STATUS, GP_MSG_RUN_ENG, GP_MSG_RUN_PWR,
    GP_MSG_IDLE, GP_MSG_STOP_ENG, GP_MSG_STOP_PWR, GP_MSG_STOP_FLT, GP_MSG_FAULT,
    GP_MSG_HIST
  } gp_msg_t;
endpackage

// ==== rtl/gp_mem_if.sv ====
// Purpose: Carrier between panel logic and its fault history memory.
// Assumes: Single clock, one write and one registered read port.
// Notes: Read data lags the address by one clock.
`timescale 1ns/1ps
`default_nettype none
interface gp_mem_if;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [15:0] wr_data;
  logic [3:0] rd_addr;
  logic [15:0] rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ==== rtl/gp_fault_mem.sv ====
// Purpose: Ten-entry store of shutdown fault codes.
// Assumes: Addresses stay below the depth; the caller wraps them.
// Notes: Contents are not reset, only the read register is.
`timescale 1ns/1ps
`default_nettype none
module gp_fault_mem
  import gp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  gp_mem_if.mem m
);
  logic [GP_CODE_W-1:0] store_mem [GP_HIST_DEPTH];

  // Write port
  always_ff @(posedge clk) begin
    if (m.wr_en) begin
      store_mem[m.wr_addr] <= m.wr_data;
    end
  end

  // Registered read keeps the output glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      m.rd_data <= 16'h0000;
    end else begin
      m.rd_data <= store_mem[m.rd_addr];
    end
  end
endmodule
`default_nettype wire

// ==== rtl/gp_panel.sv ====
// Purpose: Operator panel supervisor: modes, lamps, messages, history, trim.
// Assumes: Buttons are debounced outside; pins are asynchronous to clk.
// Notes: AHB-Lite slave answers with zero wait states, always OKAY.
// What this block does
// - Running lamp only at rated speed and voltage, off in warm-up, cool-down.
// - Shutdown lamp lights on shutdown condition; no start honoured while lit.
// - Shutdown lamp clears only on reset press after condition is gone.
// - Warning lamp follows warning condition directly, no acknowledge.
// - Remote lamp lit while a remote run request arrives.
// - Auto lamp lit exactly while mode is auto.
// - Stop in manual run shuts down skipping time-delay stop.
// - Manual run ignores all remote start requests.
// - Start press enters manual run and requests a start.
// - Auto press enters auto; remote contact then governs running.
// - Stop press requests shutdown, resets faults, returns to off.
// - History presses show newest fault, then older, wrapping over the stored count.
// - Thirty idle seconds while browsing return display to home screens.
// - Plus and minus presses move voltage setpoint by one volt.
// - Trim saturates at plus five, minus fifteen percent of nominal.
// - Establishing message at power-up until link exists, then status.
// - Running display alternates engine and power pages every five seconds.
// - Run/idle selector picks idle speed; idle shows idling message.
// - Stopped display alternates engine page with power or fault page.
// - Link loss shows re-establishing message; recovery restores prior message.
// - Shutdown faults stay until acknowledged and cleared; re-detection re-announces.
// - Mode selection works during establishing or re-establishing messages.
// - Off refuses starts and shuts down a running set.
// - Auto remote start waits preheat and start delays; removal waits stop delay.
`timescale 1ns/1ps
`default_nettype none
module gp_panel
  import gp_pkg::*;
#(
  parameter int TICK_CYCLES = GP_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic btn_start,
  input wire logic btn_auto,
  input wire logic btn_stop,
  input wire logic btn_hist,
  input wire logic btn_plus,
  input wire logic btn_minus,
  input wire logic sel_idle,
  input wire logic remote_run,
  input wire logic link_up,
  input wire logic set_running,
  input wire logic at_rated,
  input wire logic warm_cool,
  input wire logic shut_cond,
  input wire logic warn_cond,
  input wire logic [15:0] fault_code,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic lamp_run,
  output logic lamp_shutdown,
  output logic lamp_warning,
  output logic lamp_remote,
  output logic lamp_auto,
  output logic lamp_manual,
  output logic run_req,
  output logic stop_fast,
  output logic fault_reset,
  output logic idle_req,
  output logic [9:0] volt_set,
  output logic [3:0] disp_msg,
  output logic [15:0] hist_code
);
  localparam int PIN_W = 30;
  localparam logic [26:0] TICK_LAST = 27'(TICK_CYCLES - 1);

  // Clamp a trim step into the window for the chosen nominal
  function automatic logic [9:0] trim_clamp(input logic [10:0] v, input logic n240);
    logic [9:0] hi;
    logic [9:0] lo;
    hi = n240 ? GP_MAX_240 : GP_MAX_480;
    lo = n240 ? GP_MIN_240 : GP_MIN_480;
    if (v > {1'b0, hi}) begin
      trim_clamp = hi;
    end else if (v < {1'b0, lo}) begin
      trim_clamp = lo;
    end else begin
      trim_clamp = v[9:0];
    end
  endfunction

  // Age of a history slot, newest at zero, mapped to a memory address
  function automatic logic [3:0] hist_addr(input logic [3:0] ptr, input logic [3:0] age);
    logic [4:0] a;
    a = {1'b0, ptr} + {1'b0, GP_HIST_DEPTH} - 5'h01 - {1'b0, age};
    if (a >= {1'b0, GP_HIST_DEPTH}) begin
      a = a - {1'b0, GP_HIST_DEPTH};
    end
    hist_addr = a[3:0];
  endfunction

  gp_mem_if mif ();
  gp_fault_mem u_mem (.clk(clk), .rst(rst), .m(mif.mem));

  // Two-stage synchronisers for every pin
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  assign pin_raw = {fault_code, warn_cond, shut_cond, warm_cool, at_rated, set_running,
                    link_up, remote_run, sel_idle, btn_minus, btn_plus, btn_hist,
                    btn_stop, btn_auto, btn_start};
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic remote_s, link_s, running_s, rated_s, warm_s, shut_s, warn_s, idle_s;
  logic [15:0] code_s;
  assign idle_s = sync2_reg[6];
  assign remote_s = sync2_reg[7];
  assign link_s = sync2_reg[8];
  assign running_s = sync2_reg[9];
  assign rated_s = sync2_reg[10];
  assign warm_s = sync2_reg[11];
  assign shut_s = sync2_reg[12];
  assign warn_s = sync2_reg[13];
  assign code_s = sync2_reg[29:14];

  // Press edges, plus shutdown condition edge for re-announcement
  logic [5:0] btn_prev_reg;
  logic shut_prev_reg;
  logic [5:0] press;
  logic shut_rise;
  always_ff @(posedge clk) begin
    if (rst) begin
      btn_prev_reg <= 6'h00;
      shut_prev_reg <= 1'b0;
    end else begin
      btn_prev_reg <= sync2_reg[5:0];
      shut_prev_reg <= shut_s;
    end
  end
  assign press = sync2_reg[5:0] & ~btn_prev_reg;
  assign shut_rise = shut_s & ~shut_prev_reg;
  logic p_start, p_auto, p_stop, p_hist, p_plus, p_minus, any_key;
  assign p_start = press[0];
  assign p_auto = press[1];
  assign p_stop = press[2];
  assign p_hist = press[3];
  assign p_plus = press[4];
  assign p_minus = press[5];
  assign any_key = |press;

  logic [26:0] tick_cnt_reg;
  logic tick_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= 27'h0000000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == TICK_LAST);
      tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 27'h0000000 : tick_cnt_reg + 27'h0000001;
    end
  end

  // Control register written over the bus
  logic [31:0] ctrl_reg;
  logic nom240;
  logic [7:0] pre_dly, start_dly, stop_dly;
  logic [8:0] start_tgt;
  assign nom240 = ctrl_reg[GP_CTRL_NOM240_BIT];
  assign pre_dly = ctrl_reg[GP_CTRL_PRE_LSB +: 8];
  assign start_dly = ctrl_reg[GP_CTRL_START_LSB +: 8];
  assign stop_dly = ctrl_reg[GP_CTRL_STOP_LSB +: 8];
  assign start_tgt = {1'b0, pre_dly} + {1'b0, start_dly};

  // Mode selection, stop wins over start, start over auto
  gp_mode_t mode_reg;
  gp_mode_t mode_next;
  always_comb begin
    mode_next = mode_reg;
    // mode keys never wait for the link
    if (p_stop) begin
      mode_next = GP_OFF;
    end else if (p_start) begin
      mode_next = GP_MANUAL;
    end else if (p_auto) begin
      mode_next = GP_AUTO;
    end
  end
  // mode lamps share the mode update so they never lag
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= GP_OFF;
      lamp_auto <= 1'b0;
      lamp_manual <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      lamp_auto <= (mode_next == GP_AUTO);
      lamp_manual <= (mode_next == GP_MANUAL);
    end
  end

  // Shutdown lamp and fault acknowledgement
  logic flt_unack_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      lamp_shutdown <= 1'b0;
      flt_unack_reg <= 1'b0;
      fault_reset <= 1'b0;
    end else begin
      fault_reset <= p_stop;
      // a reset press cannot clear a live condition
      if (shut_s) begin
        lamp_shutdown <= 1'b1;
      end else if (p_stop) begin
        lamp_shutdown <= 1'b0;
      end
      // fresh detection wins over the acknowledge
      if (shut_rise) begin
        flt_unack_reg <= 1'b1;
      end else if (p_stop) begin
        flt_unack_reg <= 1'b0;
      end
    end
  end

  // Run request sequencing with start and stop delays in seconds
  logic [8:0] dly_cnt_reg;
  logic auto_want;
  assign auto_want = remote_s;
  always_ff @(posedge clk) begin
    if (rst) begin
      run_req <= 1'b0;
      stop_fast <= 1'b0;
      dly_cnt_reg <= 9'h000;
    end else if (lamp_shutdown || p_stop || mode_reg == GP_OFF) begin
      // no start while shutdown lamp lit
      run_req <= 1'b0;
      dly_cnt_reg <= 9'h000;
      // manual stop skips the time-delay stop
      if (p_stop) begin
        stop_fast <= 1'b1;
      end
    end else if (mode_reg == GP_MANUAL) begin
      // remote input not consulted in manual
      // manual run keeps the start request up
      run_req <= 1'b1;
      stop_fast <= 1'b0;
      dly_cnt_reg <= 9'h000;
    end else begin
      stop_fast <= 1'b0;
      // delays before starting and before stopping
      if (auto_want == run_req) begin
        dly_cnt_reg <= 9'h000;
      end else if (!run_req && dly_cnt_reg >= start_tgt) begin
        run_req <= 1'b1;
        dly_cnt_reg <= 9'h000;
      end else if (run_req && dly_cnt_reg >= {1'b0, stop_dly}) begin
        run_req <= 1'b0;
        dly_cnt_reg <= 9'h000;
      end else if (tick_reg) begin
        dly_cnt_reg <= dly_cnt_reg + 9'h001;
      end
    end
  end

  // Status lamps and idle request from synchronised inputs
  always_ff @(posedge clk) begin
    if (rst) begin
      lamp_run <= 1'b0;
      lamp_warning <= 1'b0;
      lamp_remote <= 1'b0;
      idle_req <= 1'b0;
    end else begin
      // rated and not in warm-up or cool-down
      lamp_run <= running_s & rated_s & ~warm_s;
      lamp_warning <= warn_s;
      lamp_remote <= remote_s;
      idle_req <= idle_s;
    end
  end

  // Fault log: each new shutdown stores its code
  logic [3:0] wr_ptr_reg;
  logic [3:0] hist_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= 4'h0;
      hist_cnt_reg <= 4'h0;
    end else if (shut_rise) begin
      wr_ptr_reg <= (wr_ptr_reg == GP_HIST_DEPTH - 4'h1) ? 4'h0 : wr_ptr_reg + 4'h1;
      if (hist_cnt_reg != GP_HIST_DEPTH) begin
        hist_cnt_reg <= hist_cnt_reg + 4'h1;
      end
    end
  end

  // History browsing and its idle timeout, paused while the link is down
  logic browse_reg;
  logic [3:0] hist_age_reg;
  logic [4:0] idle_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      browse_reg <= 1'b0;
      hist_age_reg <= 4'h0;
      idle_cnt_reg <= 5'h00;
    end else begin
      if (any_key) begin
        idle_cnt_reg <= 5'h00;
      end else if (browse_reg && link_s && tick_reg) begin
        idle_cnt_reg <= idle_cnt_reg + 5'h01;
      end
      // newest first, then older, wrapping over the stored count
      if (p_hist) begin
        browse_reg <= 1'b1;
        if (!browse_reg || hist_age_reg + 4'h1 >= hist_cnt_reg) begin
          hist_age_reg <= 4'h0;
        end else begin
          hist_age_reg <= hist_age_reg + 4'h1;
        end
      end else if (browse_reg && idle_cnt_reg == GP_BROWSE_TIMEOUT_S - 5'h01 && tick_reg
                   && link_s && !any_key) begin
        browse_reg <= 1'b0;
      end
    end
  end
  assign mif.wr_en = shut_rise;
  assign mif.wr_addr = wr_ptr_reg;
  assign mif.wr_data = code_s;
  assign mif.rd_addr = hist_addr(wr_ptr_reg, hist_age_reg);
  assign hist_code = mif.rd_data;

  // Voltage trim: new nominal reloads the setpoint
  logic nom_prev_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      volt_set <= GP_NOM_480;
      nom_prev_reg <= 1'b0;
    end else begin
      nom_prev_reg <= nom240;
      if (nom240 != nom_prev_reg) begin
        volt_set <= nom240 ? GP_NOM_240 : GP_NOM_480;
      end else if (p_plus && !p_minus) begin
        volt_set <= trim_clamp({1'b0, volt_set} + {1'b0, GP_TRIM_STEP_V}, nom240);
      end else if (p_minus && !p_plus) begin
        volt_set <= trim_clamp({1'b0, volt_set} - {1'b0, GP_TRIM_STEP_V}, nom240);
      end
    end
  end

  // Page alternation and power-up status; frozen while link is down
  logic [2:0] alt_cnt_reg;
  logic alt_page_reg;
  logic link_seen_reg;
  logic first_up_reg;
  logic last_flt_reg;
  logic run_prev_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      alt_cnt_reg <= 3'h0;
      alt_page_reg <= 1'b0;
      link_seen_reg <= 1'b0;
      first_up_reg <= 1'b1;
      last_flt_reg <= 1'b0;
      run_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= running_s;
      if (link_s) begin
        link_seen_reg <= 1'b1;
      end
      if (run_prev_reg && !running_s) begin
        last_flt_reg <= lamp_shutdown | shut_s;
      end
      if (link_s && tick_reg) begin
        if (alt_cnt_reg == GP_ALT_PERIOD_S - 3'h1) begin
          alt_cnt_reg <= 3'h0;
          alt_page_reg <= ~alt_page_reg;
          first_up_reg <= 1'b0;
        end else begin
          alt_cnt_reg <= alt_cnt_reg + 3'h1;
        end
      end
    end
  end

  // Message selection
  gp_msg_t main_msg;
  always_comb begin
    if (browse_reg) begin
      main_msg = GP_MSG_HIST;
    end else if (flt_unack_reg || shut_s) begin
      main_msg = GP_MSG_FAULT;
    end else if (idle_s) begin
      main_msg = GP_MSG_IDLE;
    end else if (first_up_reg) begin
      main_msg = GP_MSG_STATUS;
    end else if (running_s) begin
      main_msg = alt_page_reg ? GP_MSG_RUN_PWR : GP_MSG_RUN_ENG;
    end else if (!alt_page_reg) begin
      main_msg = GP_MSG_STOP_ENG;
    end else begin
      main_msg = last_flt_reg ? GP_MSG_STOP_FLT : GP_MSG_STOP_PWR;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      disp_msg <= GP_MSG_ESTAB;
    end else if (!link_s) begin
      disp_msg <= link_seen_reg ? GP_MSG_REESTAB : GP_MSG_ESTAB;
    end else begin
      disp_msg <= main_msg;
    end
  end

  // AHB-Lite slave, zero wait states
  logic wr_pend_reg;
  logic [7:0] wr_ofs_reg;
  logic acc;
  assign acc = hsel & hready & htrans[1];
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
      ctrl_reg <= GP_CTRL_RST;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= acc & hwrite;
      wr_ofs_reg <= haddr[7:0];
      if (wr_pend_reg && wr_ofs_reg == GP_CTRL_OFS) begin
        ctrl_reg <= hwdata;
      end
      if (acc && !hwrite) begin
        case (haddr[7:0])
          GP_CTRL_OFS: hrdata <= ctrl_reg;
          GP_STAT_OFS: hrdata <= {12'h000, hist_cnt_reg, 2'h0, stop_fast, run_req, disp_msg,
                                  lamp_manual, lamp_auto, lamp_remote, lamp_warning,
                                  lamp_shutdown, lamp_run, mode_reg};
          GP_TRIM_OFS: hrdata <= {22'h000000, volt_set};
          GP_HIST_OFS: hrdata <= {16'h0000, hist_code};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks
  run_lamp_a: assert property (@(posedge clk) disable iff (rst)
    lamp_run |-> $past(running_s & rated_s & ~warm_s)) else $error("run lamp wrong");
  shut_start_a: assert property (@(posedge clk) disable iff (rst)
    lamp_shutdown |=> !run_req) else $error("start while shutdown lamp lit");
  shut_clear_a: assert property (@(posedge clk) disable iff (rst)
    $fell(lamp_shutdown) |-> $past(p_stop & ~shut_s)) else $error("bad lamp clear");
  warn_follow_a: assert property (@(posedge clk) disable iff (rst)
    ##1 lamp_warning == $past(warn_s)) else $error("warning lamp lag");
  auto_lamp_a: assert property (@(posedge clk) disable iff (rst)
    lamp_auto == (mode_reg == GP_AUTO)) else $error("auto lamp mismatch");
  manual_stop_a: assert property (@(posedge clk) disable iff (rst)
    (p_stop && mode_reg == GP_MANUAL) |=> (stop_fast && !run_req)) else $error("stop slow");
  trim_window_a: assert property (@(posedge clk) disable iff (rst)
    (nom240 == nom_prev_reg) |-> (nom240 ? (volt_set <= GP_MAX_240 && volt_set >= GP_MIN_240)
    : (volt_set <= GP_MAX_480 && volt_set >= GP_MIN_480))) else $error("trim out of range");
  browse_to_a: assert property (@(posedge clk) disable iff (rst)
    browse_reg |-> idle_cnt_reg < GP_BROWSE_TIMEOUT_S) else $error("browse timeout missed");
  comm_msg_a: assert property (@(posedge clk) disable iff (rst)
    !link_s |=> (disp_msg == GP_MSG_ESTAB || disp_msg == GP_MSG_REESTAB))
    else $error("no comm message");
  hist_wrap_a: assert property (@(posedge clk) disable iff (rst)
    hist_age_reg < GP_HIST_DEPTH) else $error("history index past depth");
  alt_swap_a: assert property (@(posedge clk) disable iff (rst)
    $changed(alt_page_reg) |-> $past(tick_reg && alt_cnt_reg == 3'h4))
    else $error("page swap off period");
endmodule
`default_nettype wire

// ==== dv/gp_board_model.sv ====
// Purpose: Behavioural main control board behind the panel.
// Assumes: Set spins up a few clocks after run_req rises.
// Notes: Warm-up comes first, so the run lamp must wait for rated.
`timescale 1ns/1ps
`default_nettype none
module gp_board_model (
  input wire logic clk,
  input wire logic run_req,
  output logic set_running = 1'b0,
  output logic at_rated = 1'b0,
  output logic warm_cool = 1'b0
);
  logic [2:0] age_reg = 3'h0;
  always_ff @(posedge clk) begin
    age_reg <= (run_req && age_reg != 3'h7) ? age_reg + 3'h1 : (run_req ? age_reg : 3'h0);
    set_running <= run_req;
    warm_cool <= run_req && age_reg < 3'h4;
    at_rated <= run_req && age_reg >= 3'h4;
  end
endmodule
`default_nettype wire

// ==== dv/tb_genset_operator_panel_control.sv ====
// Purpose: Self-checking bench for the panel supervisor.
// Assumes: Tick shortened to 20 clocks; all CTRL delays zero.
// Notes: Lamp checks pass through a queue to a monitor process.
`timescale 1ns/1ps
`default_nettype none
module tb_genset_operator_panel_control;
  import gp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] btn = 6'h00; // Start, auto, stop, hist, plus, minus
  logic remote_run = 1'b0, link_up = 1'b0, shut_cond = 1'b0, warn_cond = 1'b0;
  logic [15:0] fault_code = 16'h0000;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, set_running, at_rated, warm_cool, run_req, stop_fast;
  logic lamp_run, lamp_shutdown, lamp_warning, lamp_remote, lamp_auto, lamp_manual;
  logic [9:0] volt_set;
  logic [3:0] disp_msg;
  logic [15:0] hist_code, c1, c2;
  logic fault_reset, idle_req, sel_idle = 1'b0;
  int fr = 0;
  logic [31:0] q[$];
  int mismatches = 0, checked = 0, cyc = 0, n;
  event ev;
  always #5 clk = ~clk;
  gp_panel #(.TICK_CYCLES(20)) dut_u (.clk(clk), .rst(rst), .btn_start(btn[0]),
    .btn_auto(btn[1]), .btn_stop(btn[2]), .btn_hist(btn[3]), .btn_plus(btn[4]),
    .btn_minus(btn[5]), .sel_idle(sel_idle), .remote_run(remote_run), .link_up(link_up),
    .set_running(set_running), .at_rated(at_rated), .warm_cool(warm_cool),
    .shut_cond(shut_cond), .warn_cond(warn_cond), .fault_code(fault_code), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .lamp_run(lamp_run), .lamp_shutdown(lamp_shutdown), .lamp_warning(lamp_warning),
    .lamp_remote(lamp_remote), .lamp_auto(lamp_auto), .lamp_manual(lamp_manual),
    .run_req(run_req), .stop_fast(stop_fast), .fault_reset(fault_reset), .idle_req(idle_req),
    .volt_set(volt_set), .disp_msg(disp_msg), .hist_code(hist_code));
  gp_board_model brd_u (.clk(clk), .run_req(run_req), .set_running(set_running),
    .at_rated(at_rated), .warm_cool(warm_cool));
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic msg(input gp_msg_t e);
    cmp(32'(e), {28'h0, disp_msg});
  endtask
  // Count fault reset pulses off the launch edge, one per stop press
  always @(negedge clk) begin
    if (fault_reset === 1'b1) begin
      fr++;
    end
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Release between presses, since only rising edges count
  task automatic press(input int i);
    btn[i] <= 1'b1;
    step(2);
    btn[i] <= 1'b0;
    step(6);
  endtask
  // Note {run,shut,warn,remote,auto,manual,run_req,stop_fast}
  task automatic expect_l(input logic [7:0] e);
    q.push_back({24'h0, e});
    ->ev;
    step(1);
  endtask
  // Monitor samples at the falling edge, clear of launch races
  always @(ev) begin
    @(negedge clk);
    cmp(q.pop_front(), {24'h0, lamp_run, lamp_shutdown, lamp_warning, lamp_remote,
      lamp_auto, lamp_manual, run_req, stop_fast});
  end
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    n = $urandom(68162);
    step(10);
    rst <= 1'b0;
    step(1);
    ahb(1'b0, GP_STAT_OFS, 32'h0);
    cmp(32'h0, rd);
    cmp({22'h0, GP_NOM_480}, {22'h0, volt_set});
    $display("test reset done");
    remote_run <= 1'b1;
    press(0);
    step(10);
    expect_l(8'h96);
    link_up <= 1'b1;
    press(2);
    step(4);
    expect_l(8'h11);
    press(1);
    step(60);
    expect_l(8'h9A);
    remote_run <= 1'b0;
    step(40);
    expect_l(8'h08);
    $display("test modes done");
    c1 = 16'($urandom);
    fault_code <= c1;
    shut_cond <= 1'b1;
    warn_cond <= 1'b1;
    step(6);
    press(0);
    expect_l(8'h64);
    press(2);
    expect_l(8'h61);
    shut_cond <= 1'b0;
    warn_cond <= 1'b0;
    step(6);
    expect_l(8'h41);
    press(2);
    expect_l(8'h01);
    $display("test shutdown done");
    ahb(1'b1, GP_CTRL_OFS, 32'h1);
    step(4);
    cmp({22'h0, GP_NOM_240}, {22'h0, volt_set});
    n = $urandom_range(40, 20);
    repeat (n) press(5);
    cmp((240 - n < 204) ? 32'd204 : 32'(240 - n), {22'h0, volt_set});
    repeat (60) press(4);
    ahb(1'b0, GP_TRIM_OFS, 32'h0);
    cmp({22'h0, GP_MAX_240}, rd & 32'h3FF);
    ahb(1'b0, 8'h10, 32'h0);
    cmp(32'h0, rd);
    $display("test trim done");
    sel_idle <= 1'b1;
    step(4);
    msg(GP_MSG_IDLE);
    cmp(32'h1, {31'h0, idle_req});
    sel_idle <= 1'b0;
    link_up <= 1'b0;
    step(4);
    msg(GP_MSG_REESTAB);
    link_up <= 1'b1;
    c2 = 16'($urandom);
    fault_code <= c2;
    step(4);
    shut_cond <= 1'b1;
    step(6);
    msg(GP_MSG_FAULT);
    press(2);
    msg(GP_MSG_FAULT);
    shut_cond <= 1'b0;
    step(6);
    press(2);
    expect_l(8'h01);
    press(3);
    msg(GP_MSG_HIST);
    cmp({16'h0, c2}, {16'h0, hist_code});
    press(3);
    cmp({16'h0, c1}, {16'h0, hist_code});
    press(3);
    cmp({16'h0, c2}, {16'h0, hist_code});
    step(560);
    msg(GP_MSG_HIST);
    step(60);
    cmp(32'h1, {31'h0, disp_msg != GP_MSG_HIST});
    cmp(32'd5, 32'(fr));
    $display("test display done");
    wrap_up();
  end
endmodule
`default_nettype wire
